// ==== hdl/oadc_pkg.sv ====
// constants and carrier types for the octal converter serial output control
package oadc_pkg;

  localparam int NUM_CH = 8;
  localparam int WORD_W = 12;
  localparam logic [WORD_W-1:0] TEST_WORD = 12'h0bd;

  localparam int BITS_PER_FRAME = 12;
  localparam int FRAME_HIGH_BITS = 6;
  localparam logic [3:0] BIT_CNT_LAST = 4'hb;
  localparam logic [3:0] BIT_CNT_RST = 4'hb;
  localparam logic [3:0] FRAME_HIGH_CNT = 4'h6;

  // 13 half-cycle stages after the sampling register give 6.5 cycles
  localparam int LAT_HALF_STAGES = 13;

  localparam int SYNC_STAGES = 3;

  localparam int LOCK_WORDS = 4;
  localparam int PER_CNT_W = 5;
  localparam logic [PER_CNT_W-1:0] PER_CNT_MATCH = 5'h0b;
  localparam logic [2:0] LOCK_CNT_FULL = 3'h4;

  localparam int CLOCK_HZ = 125_000_000;
  localparam int REF_SETTLE_MS = 100;
  localparam int REF_SETTLE_CYCLES = REF_SETTLE_MS * (CLOCK_HZ / 1000);
  localparam int REF_CNT_W = 24;

  localparam logic [2:0] RANGE_UNUSED = 3'h0;
  localparam logic [2:0] RANGE_RST = 3'h0;

  typedef struct packed {
    logic test_pattern_enable;
    logic format_select;
    logic power_down_input;
    logic clock_range_select_1;
    logic clock_range_select_2;
    logic clock_range_select_3;
  } oadc_strap_t;

  localparam int STRAP_W = $bits(oadc_strap_t);
  localparam logic [STRAP_W-1:0] STRAP_RST = 6'h08;

  typedef struct packed {
    logic [NUM_CH-1:0][WORD_W-1:0] code;
  } oadc_lanes_t;

endpackage

// ==== hdl/oadc_lane_ser.sv ====
// one differential output lane: 12-bit word shifted out lsb first
`timescale 1ns/1ps
module oadc_lane_ser
  import oadc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [WORD_W-1:0] word,
  output logic bit_pos,
  output logic bit_neg
);

  logic [WORD_W-1:0] shift_q;

  always_ff @(posedge clock) begin
    if (sys_rst || clear) begin
      shift_q <= '0;
    end else if (load) begin
      shift_q <= word;
    end else begin
      shift_q <= {1'b0, shift_q[WORD_W-1:1]};
    end
  end

  // both legs low while cleared, standing in for the disabled driver
  always_ff @(posedge clock) begin
    if (sys_rst || clear) begin
      bit_pos <= 1'b0;
      bit_neg <= 1'b0;
    end else if (load) begin
      bit_pos <= word[0];
      bit_neg <= ~word[0];
    end else begin
      bit_pos <= shift_q[1];
      bit_neg <= ~shift_q[1];
    end
  end

endmodule

// ==== hdl/oadc_serout.sv ====
// sampling pipeline, domain crossing and serial lane output of the octal converter
`timescale 1ns/1ps
module oadc_serout
  import oadc_pkg::*;
#(
  parameter int REF_SETTLE_CYC = REF_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sample_clk,
  input wire oadc_strap_t strap_pins,
  input wire oadc_lanes_t conv_in,
  output logic [NUM_CH-1:0] lane_pos,
  output logic [NUM_CH-1:0] lane_neg,
  output logic frame_align_pos,
  output logic frame_align_neg,
  output logic serial_clock_pos,
  output logic serial_clock_neg,
  output logic output_enable,
  output logic ref_ready,
  output logic [2:0] range_code,
  output logic range_invalid,
  output logic frame_locked,
  output logic frame_resync
);

  // ---------------- sample clock domain ----------------

  logic [SYNC_STAGES-1:0] srst_sync_q;
  logic srst_q;
  logic [SYNC_STAGES-1:0] spd_sync_q;
  logic spd_q;
  logic s_hold;

  // reset and power-down reach the sample domain through three flops;
  // a change counts only when the last two agree
  always_ff @(posedge sample_clk) begin
    srst_sync_q <= {srst_sync_q[SYNC_STAGES-2:0], sys_rst};
    if (srst_sync_q[1] == srst_sync_q[2]) begin
      srst_q <= srst_sync_q[2];
    end
  end

  always_ff @(posedge sample_clk) begin
    if (srst_q) begin
      spd_sync_q <= '1;
      spd_q <= 1'b1;
    end else begin
      spd_sync_q <= {spd_sync_q[SYNC_STAGES-2:0], strap_pins.power_down_input};
      if (spd_sync_q[1] == spd_sync_q[2]) begin
        spd_q <= spd_sync_q[2];
      end
    end
  end

  assign s_hold = srst_q || spd_q;

  // stage 0 samples all channels together on the rising edge; later stages
  // alternate falling and rising edges, one stage per half period
  genvar k;
  generate
    for (k = 0; k <= LAT_HALF_STAGES; k++) begin : g_stage
      oadc_lanes_t stage_q;
      if (k == 0) begin : g_sample
        always_ff @(posedge sample_clk) begin
          if (s_hold) begin
            stage_q <= '0;
          end else begin
            stage_q <= conv_in;
          end
        end
      end else if (k % 2 == 1) begin : g_fall
        always_ff @(negedge sample_clk) begin
          if (s_hold) begin
            stage_q <= '0;
          end else begin
            stage_q <= g_stage[k-1].stage_q;
          end
        end
      end else begin : g_rise
        always_ff @(posedge sample_clk) begin
          if (s_hold) begin
            stage_q <= '0;
          end else begin
            stage_q <= g_stage[k-1].stage_q;
          end
        end
      end
    end
  endgenerate

  // the last stage settles on a falling edge, 6.5 cycles after sampling;
  // the toggle announces it and the word stays put for a whole period
  logic word_tgl_q;

  always_ff @(negedge sample_clk) begin
    if (srst_q) begin
      word_tgl_q <= 1'b0;
    end else if (!spd_q) begin
      word_tgl_q <= ~word_tgl_q;
    end
  end

  oadc_lanes_t word_hold;
  assign word_hold = g_stage[LAT_HALF_STAGES].stage_q;

  // ---------------- bit clock domain ----------------

  logic [STRAP_W-1:0] strap_s0_q;
  logic [STRAP_W-1:0] strap_s1_q;
  logic [STRAP_W-1:0] strap_s2_q;
  logic [STRAP_W-1:0] strap_bits_q;
  oadc_strap_t strap_q;

  // per bit: follow the pin once the last two flops agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_s0_q <= STRAP_RST;
      strap_s1_q <= STRAP_RST;
      strap_s2_q <= STRAP_RST;
      strap_bits_q <= STRAP_RST;
    end else begin
      strap_s0_q <= strap_pins;
      strap_s1_q <= strap_s0_q;
      strap_s2_q <= strap_s1_q;
      strap_bits_q <= (strap_s2_q & ~(strap_s1_q ^ strap_s2_q)) | (strap_bits_q & (strap_s1_q ^ strap_s2_q));
    end
  end

  assign strap_q = strap_bits_q;

  logic pd_active;
  assign pd_active = strap_q.power_down_input;

  logic [SYNC_STAGES-1:0] tgl_sync_q;
  logic tgl_q;
  logic tgl_prev_q;
  logic fresh_word;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tgl_sync_q <= '0;
      tgl_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[SYNC_STAGES-2:0], word_tgl_q};
      if (tgl_sync_q[1] == tgl_sync_q[2]) begin
        tgl_q <= tgl_sync_q[2];
      end
      tgl_prev_q <= tgl_q;
    end
  end

  assign fresh_word = tgl_q ^ tgl_prev_q;

  // the held word is read only after its toggle has crossed, so it is stable
  oadc_lanes_t word_q;
  logic fresh_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      word_q <= '0;
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= fresh_word && !pd_active;
      if (fresh_word) begin
        word_q <= word_hold;
      end
    end
  end

  // frame timing: a fresh word restarts the frame, so frames follow the
  // sample clock; without one the frame wraps after twelve bit times
  logic [3:0] bit_cnt_q;
  logic frame_end;
  logic load;
  logic [3:0] bit_cnt_d;

  assign frame_end = (bit_cnt_q == BIT_CNT_LAST);
  assign load = fresh_q || frame_end;
  assign bit_cnt_d = load ? 4'h0 : bit_cnt_q + 4'h1;

  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      bit_cnt_q <= BIT_CNT_RST;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // a fresh word before the frame ends means the ratio is off; flag it
  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      frame_resync <= 1'b0;
    end else begin
      frame_resync <= fresh_q && !frame_end;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      frame_align_pos <= 1'b0;
      frame_align_neg <= 1'b0;
    end else begin
      frame_align_pos <= (bit_cnt_d < FRAME_HIGH_CNT);
      frame_align_neg <= !(bit_cnt_d < FRAME_HIGH_CNT);
    end
  end

  // forwarded clock toggles every bit time: six periods per word, one
  // data bit per edge; it is forced high with the first bit of each word
  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      serial_clock_pos <= 1'b0;
      serial_clock_neg <= 1'b0;
    end else if (load) begin
      serial_clock_pos <= 1'b1;
      serial_clock_neg <= 1'b0;
    end else begin
      serial_clock_pos <= ~serial_clock_pos;
      serial_clock_neg <= serial_clock_pos;
    end
  end

  // lanes: select the word, then shift it out on the channel's own pair
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_lane
      logic [WORD_W-1:0] code;
      logic [WORD_W-1:0] lane_word;

      assign code = word_q.code[ch];

      always_comb begin
        lane_word = code;
        if (strap_q.test_pattern_enable) begin
          lane_word = TEST_WORD;
        end else if (!strap_q.format_select) begin
          lane_word = {~code[WORD_W-1], code[WORD_W-2:0]};
        end
      end

      oadc_lane_ser u_lane (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(pd_active),
        .load(load),
        .word(lane_word),
        .bit_pos(lane_pos[ch]),
        .bit_neg(lane_neg[ch])
      );
    end
  endgenerate

  // lock: fresh words arrive exactly twelve bit times apart several times running
  logic [PER_CNT_W-1:0] per_cnt_q;
  logic [2:0] lock_cnt_q;

  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      per_cnt_q <= '0;
      lock_cnt_q <= '0;
    end else if (fresh_q) begin
      per_cnt_q <= '0;
      if (per_cnt_q != PER_CNT_MATCH) begin
        lock_cnt_q <= '0;
      end else if (lock_cnt_q != LOCK_CNT_FULL) begin
        lock_cnt_q <= lock_cnt_q + 3'h1;
      end
    end else if (per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + 5'h01;
    end else begin
      lock_cnt_q <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      frame_locked <= 1'b0;
    end else begin
      frame_locked <= (lock_cnt_q == LOCK_CNT_FULL);
    end
  end

  // reference settling: the receiver should ignore data until this rises
  logic [REF_CNT_W-1:0] ref_cnt_q;

  always_ff @(posedge clock) begin
    if (sys_rst || pd_active) begin
      ref_cnt_q <= '0;
      ref_ready <= 1'b0;
    end else if (ref_cnt_q == REF_CNT_W'(REF_SETTLE_CYC - 1)) begin
      ref_ready <= 1'b1;
    end else begin
      ref_cnt_q <= ref_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_enable <= 1'b0;
    end else begin
      output_enable <= !pd_active;
    end
  end

  // the multiplier itself sits outside; the range is only reported
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      range_code <= RANGE_RST;
      range_invalid <= 1'b1;
    end else begin
      range_code <= {strap_q.clock_range_select_1, strap_q.clock_range_select_2,
                     strap_q.clock_range_select_3};
      range_invalid <= ({strap_q.clock_range_select_1, strap_q.clock_range_select_2,
                         strap_q.clock_range_select_3} == RANGE_UNUSED);
    end
  end

endmodule

// ==== verif/oadc_serout_chk.sv ====
// assertion checker for the octal converter serial output
`timescale 1ns/1ps
module oadc_serout_chk
  import oadc_pkg::*;
#(
  parameter int REF_SETTLE_CYC = REF_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire oadc_strap_t strap_pins,
  input wire logic [NUM_CH-1:0] lane_pos,
  input wire logic [NUM_CH-1:0] lane_neg,
  input wire logic frame_align_pos,
  input wire logic frame_align_neg,
  input wire logic serial_clock_pos,
  input wire logic serial_clock_neg,
  input wire logic output_enable,
  input wire logic ref_ready,
  input wire logic [2:0] range_code,
  input wire logic range_invalid,
  input wire logic frame_locked,
  input wire logic frame_resync
);
  localparam int REF_LO = REF_SETTLE_CYC - 3;
  localparam int REF_HI = REF_SETTLE_CYC + 3;
  logic [31:0] oe_cnt_q;
  // the power-down pin masks framing checks at once; the outputs only stop a few clocks later
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || strap_pins.power_down_input);
  always_ff @(posedge clock) begin
    if (sys_rst || !output_enable) begin
      oe_cnt_q <= 32'h0;
    end else if (oe_cnt_q != 32'hffffffff) begin
      oe_cnt_q <= oe_cnt_q + 32'h1;
    end
  end
  chk_frame_lsb: assert property ($rose(frame_align_pos) |-> serial_clock_pos)
    else $error("serial clock low at frame start");
  // the first fresh word after start-up or power-down restarts a running frame and may stretch its high time
  chk_frame_high: assert property (frame_locked && $rose(frame_align_pos) |->
    frame_align_pos [*6] ##1 !frame_align_pos)
    else $error("frame high time not six bit clocks");
  chk_frame_period: assert property (frame_locked && $rose(frame_align_pos) |-> ##12 $rose(frame_align_pos))
    else $error("word length not twelve bit clocks");
  chk_diff_legs: assert property (output_enable && $past(output_enable) |->
    lane_neg == ~lane_pos && frame_align_neg == !frame_align_pos && serial_clock_neg == !serial_clock_pos)
    else $error("negative leg not complement");
  chk_sclk_toggle: assert property (frame_locked && output_enable && $past(output_enable) |->
    serial_clock_pos != $past(serial_clock_pos))
    else $error("serial clock missed a toggle");
  chk_range_flag: assert property (range_invalid == (range_code == RANGE_UNUSED))
    else $error("range flag wrong");
  chk_pd_quiet: assert property (disable iff (sys_rst) !output_enable [*2] |->
    lane_pos == '0 && !frame_align_pos && !serial_clock_pos && !ref_ready)
    else $error("outputs active in power-down");
  chk_ref_wait: assert property (disable iff (sys_rst) $rose(ref_ready) |->
    oe_cnt_q >= REF_LO && oe_cnt_q <= REF_HI)
    else $error("reference ready at wrong time");
  chk_resync_lock: assert property (frame_resync |=> !frame_locked)
    else $error("lock kept after frame restart");
  cov_resync: cover property (frame_resync);
  cov_locked_word: cover property (frame_locked && $rose(frame_align_pos));
  cov_ref_up: cover property ($rose(ref_ready));
  cov_range_fix: cover property (range_invalid ##1 !range_invalid);
endmodule
bind oadc_serout oadc_serout_chk #(.REF_SETTLE_CYC(REF_SETTLE_CYC)) i_oadc_serout_chk (
  .clock(clock),
  .sys_rst(sys_rst),
  .strap_pins(strap_pins),
  .lane_pos(lane_pos),
  .lane_neg(lane_neg),
  .frame_align_pos(frame_align_pos),
  .frame_align_neg(frame_align_neg),
  .serial_clock_pos(serial_clock_pos),
  .serial_clock_neg(serial_clock_neg),
  .output_enable(output_enable),
  .ref_ready(ref_ready),
  .range_code(range_code),
  .range_invalid(range_invalid),
  .frame_locked(frame_locked),
  .frame_resync(frame_resync)
);

// ==== verif/oadc_rx_model.sv ====
// deserializing receiver: finds words by the frame rise, gathers lane bits lsb first
`timescale 1ns/1ps
module oadc_rx_model
  import oadc_pkg::*;
(
  input wire logic clock,
  input wire logic [NUM_CH-1:0] lane_pos,
  input wire logic frame_align_pos,
  output oadc_lanes_t rx_word,
  output logic [31:0] rx_count
);
  logic frame_q = 1'b0;
  logic [3:0] idx_q = 4'hc;
  logic [3:0] bit_idx;
  oadc_lanes_t shift_q = '0;
  oadc_lanes_t word_q = '0;
  logic [31:0] cnt_q = 32'h0;
  assign rx_word = word_q;
  assign rx_count = cnt_q;
  // a frame rise restarts the word at bit zero whatever the count says
  assign bit_idx = (frame_align_pos && !frame_q) ? 4'h0 : idx_q;
  always_ff @(posedge clock) begin
    frame_q <= frame_align_pos;
    if (bit_idx < 4'hc) begin
      idx_q <= bit_idx + 4'h1;
      for (int c = 0; c < NUM_CH; c++) begin
        shift_q.code[c][bit_idx] <= lane_pos[c];
      end
    end
    if (bit_idx == 4'hb) begin
      for (int c = 0; c < NUM_CH; c++) begin
        word_q.code[c] <= {lane_pos[c], shift_q.code[c][10:0]};
      end
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the octal converter serial output control
`timescale 1ns/1ps
module tb_top;
  import oadc_pkg::*;
  localparam int SETTLE = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_clk = 1'b0;
  oadc_strap_t strap_pins = 6'h11;
  oadc_lanes_t conv_in = '0;
  logic [NUM_CH-1:0] lane_pos;
  logic [NUM_CH-1:0] lane_neg;
  logic frame_align_pos;
  logic frame_align_neg;
  logic serial_clock_pos;
  logic output_enable;
  logic ref_ready;
  logic [2:0] range_code;
  logic range_invalid;
  logic frame_locked;
  oadc_lanes_t rx_word;
  logic [31:0] rx_count;
  int n_mismatch = 0;
  int checks = 0;
  int cnt;
  oadc_serout #(.REF_SETTLE_CYC(SETTLE)) i_oadc_serout (
    .clock(clock), .sys_rst(sys_rst), .sample_clk(sample_clk), .strap_pins(strap_pins),
    .conv_in(conv_in), .lane_pos(lane_pos), .lane_neg(lane_neg), .frame_align_pos(frame_align_pos),
    .frame_align_neg(frame_align_neg), .serial_clock_pos(serial_clock_pos), .serial_clock_neg(),
    .output_enable(output_enable), .ref_ready(ref_ready), .range_code(range_code),
    .range_invalid(range_invalid), .frame_locked(frame_locked), .frame_resync()
  );
  oadc_rx_model i_oadc_rx_model (
    .clock(clock), .lane_pos(lane_pos), .frame_align_pos(frame_align_pos),
    .rx_word(rx_word), .rx_count(rx_count)
  );
  initial begin
    forever #4 clock = ~clock;
  end
  // one converter period spans twelve bit clocks, as the bit clock stands in for the external multiplier
  initial begin
    #3.3;
    forever begin
      sample_clk = 1'b1;
      #6;
      sample_clk = 1'b0;
      #90;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] exp_word(input logic [11:0] raw);
    if (strap_pins.test_pattern_enable) return TEST_WORD;
    return strap_pins.format_select ? raw : {~raw[11], raw[10:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic word_test(input logic tp, input logic fmt);
    logic [31:0] c0;
    strap_pins.test_pattern_enable = tp;
    strap_pins.format_select = fmt;
    conv_in.code[3:0] = {12'h7ff, 12'h800, 12'hfff, 12'h000};
    for (int ch = 4; ch < NUM_CH; ch++) conv_in.code[ch] = 12'($urandom);
    tick(200);
    c0 = rx_count;
    cnt = 0;
    while (rx_count == c0 && cnt < 40) begin
      tick(1);
      cnt++;
    end
    check(32'(cnt < 40), 32'h1);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      check(32'(rx_word.code[ch]), 32'(exp_word(conv_in.code[ch])));
    end
    $display("word test tp=%0d fmt=%0d done", tp, fmt);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #60000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(83));
    // reset must span four edges of the slow converter clock, not just two bit clocks
    tick(52);
    sys_rst = 1'b0;
    tick(40);
    for (int i = 0; i < 8; i++) word_test(i[1], i[0]);
    check(32'(frame_locked), 32'h1);
    strap_pins.power_down_input = 1'b1;
    tick(20);
    check(32'({output_enable, ref_ready, lane_pos, frame_align_pos}), 32'h0);
    strap_pins.power_down_input = 1'b0;
    cnt = 0;
    while (!ref_ready && cnt < 200) begin
      tick(1);
      cnt++;
    end
    check(32'(cnt >= SETTLE && cnt < SETTLE + 8), 32'h1);
    $display("power-down test done");
    word_test(1'b0, 1'b1);
    for (int r = 0; r < 8; r++) begin
      {strap_pins.clock_range_select_1, strap_pins.clock_range_select_2, strap_pins.clock_range_select_3} = 3'(r);
      tick(8);
      check(32'({range_invalid, range_code}), 32'({r == 0, 3'(r)}));
    end
    $display("range test done");
    final_report();
  end
endmodule
